// ### src/clock_tree_pkg.sv
/*
 * Constants for the USB PLL clock tree: selector codes, divider encodings,
 * bit positions and timing counts.
 * Assumes a single 40 MHz control clock; analog sources appear as enables.
 */
`default_nettype none

package clock_tree_pkg;

    // Oscillator selector codes
    localparam logic [2:0] SEL_FRC        = 3'h0;
    localparam logic [2:0] SEL_FRC_PLL    = 3'h1;
    localparam logic [2:0] SEL_PRI        = 3'h2;
    localparam logic [2:0] SEL_PRI_PLL    = 3'h3;
    localparam logic [2:0] SEL_SECONDARY_OSC       = 3'h4;
    localparam logic [2:0] SEL_LPRC       = 3'h5;
    localparam logic [2:0] SEL_FRC_DIV16  = 3'h6;
    localparam logic [2:0] SEL_FRC_DIV    = 3'h7;

    // Secondary oscillator digital-input mode
    localparam logic [1:0] SECONDARY_OSC_MODE_DIGITAL = 2'h2;

    // Multiplier factor codes
    localparam logic [1:0] MULT_4X = 2'h0;
    localparam logic [1:0] MULT_6X = 2'h1;
    localparam logic [1:0] MULT_8X = 2'h2;

    // Frequencies in kHz
    localparam int PLL_VCO_KHZ   = 96000;
    localparam int PLL_REF_KHZ   = 4000;
    localparam int PLL_IN_MIN    = 4000;
    localparam int PLL_IN_MAX    = 48000;
    localparam int USB_KHZ       = 48000;
    localparam int SYS_BASE_KHZ  = 64000;
    localparam int FRC_KHZ       = 8000;

    // Status bit positions
    localparam int LOCK_BIT      = 5;
    localparam int KEEP_ON_BIT   = 5;

    // Lock delay
    localparam int LOCK_DELAY_US = 2;
    localparam int CLK_MHZ       = 40;
    localparam int LOCK_CYCLES   = LOCK_DELAY_US * CLK_MHZ;

    // Clock-output divide of the control clock clk_in
    localparam int CLKOUT_DIV    = 4;

endpackage : clock_tree_pkg

`default_nettype wire

// ### src/usb_pll_clock_tree.sv
/*
 * Control logic of the clock tree: PLL prescaler and branch dividers,
 * lock timer, oscillator enables, postscaler and pin repurposing.
 * Assumes clock-rate outputs are modelled as frequency figures in kHz and
 * as divider settings for the analog blocks; one clk_in domain.
 */
`default_nettype none

module usb_pll_clock_tree
    import clock_tree_pkg::*;
#(
    parameter int LOCK_COUNT = clock_tree_pkg::LOCK_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [2:0] osc_config_select_in,
    input  wire logic [2:0] new_osc_select_in,
    input  wire logic       switch_request_in,
    input  wire logic       external_clock_mode_in,
    input  wire logic       clock_out_enable_in,
    input  wire logic       sys_clk_in,
    input  wire logic [1:0] mult_factor_in,
    input  wire logic [2:0] pll_input_divider_in,
    input  wire logic [1:0] cpu_clock_divider_in,
    input  wire logic [15:0] primary_khz_in,
    input  wire logic       usb_enable_in,
    input  wire logic       usb_suspend_in,
    input  wire logic [2:0] secondary_osc_enable_in,
    input  wire logic [1:0] secondary_osc_mode_in,
    input  wire logic       sleep_in,
    input  wire logic       pll_keep_on_in,
    input  wire logic       powerup_done_in,
    input  wire logic [2:0] fast_rc_postscale_in,
    output logic [2:0]      current_osc_select_out,
    output logic [7:0]      status_out,
    output logic            clock_pin_out,
    output logic            clock_pin_oe_n_out,
    output logic            feedback_enable_out,
    output logic [3:0]      mult_ratio_out,
    output logic [3:0]      prescale_ratio_out,
    output logic            ref_valid_out,
    output logic            pll_run_out,
    output logic            usb_clk_enable_out,
    output logic [15:0]     usb_clk_khz_out,
    output logic [15:0]     sys_clk_khz_out,
    output logic            secondary_osc_run_out,
    output logic            crystal_driver_out,
    output logic            secondary_clock_input_out,
    output logic            secondary_in_is_port_out,
    output logic            fast_rc_run_out,
    output logic [15:0]     fast_rc_khz_out,
    output logic            fast_rc_pll_ok_out
);

    // Lock counter is 16 bits wide
    if (LOCK_COUNT < 1 || LOCK_COUNT > 65535) begin : g_bad_lock_count
        $error("LOCK_COUNT out of range");
    end

    // All assertions below run on the one control clock
    default clocking cb_main @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////
    // Clock source selection

    logic [2:0]  cur_sel;
    logic        digital_secondary_osc;
    logic        pll_src;
    logic        accept_sw;
    logic [15:0] lock_cnt;
    logic        locked;
    logic [1:0]  clkout_cnt;

    assign digital_secondary_osc = (secondary_osc_mode_in == SECONDARY_OSC_MODE_DIGITAL);
    assign pll_src = (cur_sel == SEL_FRC_PLL) || (cur_sel == SEL_PRI_PLL);
    // Switch taken only after power-up and outside digital mode
    assign accept_sw = switch_request_in && powerup_done_in
                    && !digital_secondary_osc;

    // Current select: FRC at reset, config until power-up done, new select on switch
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cur_sel <= SEL_FRC;
        end else if (!powerup_done_in) begin
            cur_sel <= osc_config_select_in;
        end else if (switch_request_in && !digital_secondary_osc) begin
            cur_sel <= new_osc_select_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock timer (timer based, no lock sensing)

    // Clear on any real switch, so lock never lingers off-PLL
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lock_cnt <= '0;
            locked   <= 1'b0;
        end else if (accept_sw && new_osc_select_in != cur_sel) begin
            lock_cnt <= '0;
            locked   <= 1'b0;
        end else if (!pll_src) begin
            lock_cnt <= '0;
            locked   <= 1'b0;
        end else if (!locked) begin
            if (lock_cnt == 16'(LOCK_COUNT - 1)) begin
                locked <= 1'b1;
            end
            lock_cnt <= lock_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PLL dividers and frequencies

    logic [3:0]  pre;
    logic [3:0]  mult;
    logic [15:0] ref_khz;
    logic [15:0] sys_khz;

    // Prescaler table, fixed by configuration
    always_comb begin
        case (pll_input_divider_in)
            3'h0:    pre = 4'h1;
            3'h1:    pre = 4'h2;
            3'h2:    pre = 4'h3;
            3'h3:    pre = 4'h4;
            3'h4:    pre = 4'h5;
            3'h5:    pre = 4'h6;
            3'h6:    pre = 4'h8;
            default: pre = 4'hc;
        endcase
    end

    // Multiplier factor
    always_comb begin
        case (mult_factor_in)
            MULT_6X: mult = 4'h6;
            MULT_8X: mult = 4'h8;
            default: mult = 4'h4;
        endcase
    end

    assign ref_khz = primary_khz_in / 16'(pre);

    // System branch: 96/1.5 = 64, then 1,2,4,8
    assign sys_khz = 16'(SYS_BASE_KHZ) >> cpu_clock_divider_in;

    // PLL outputs and valid reference check
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prescale_ratio_out <= 4'h1;
            mult_ratio_out     <= 4'h4;
            ref_valid_out      <= 1'b0;
            sys_clk_khz_out    <= 16'(FRC_KHZ);
        end else begin
            prescale_ratio_out <= pre;
            mult_ratio_out     <= mult;
            ref_valid_out      <= (ref_khz == 16'(PLL_REF_KHZ))
                && primary_khz_in >= 16'(PLL_IN_MIN)
                && primary_khz_in <= 16'(PLL_IN_MAX)
                && (primary_khz_in % 16'(PLL_IN_MIN)) == 16'h0000;
            sys_clk_khz_out    <= pll_src ? sys_khz : fast_rc_khz_out;
        end
    end

    // PLL run and USB clock
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pll_run_out        <= 1'b0;
            usb_clk_enable_out <= 1'b0;
            usb_clk_khz_out    <= '0;
        end else begin
            pll_run_out <= pll_src || pll_keep_on_in
                        || (usb_enable_in && !usb_suspend_in);
            usb_clk_enable_out <= usb_enable_in && !usb_suspend_in;
            usb_clk_khz_out <= (usb_enable_in && !usb_suspend_in)
                ? 16'(PLL_VCO_KHZ / 2) : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External clock pin

    // clk_in/4 output or I/O; feedback off in external mode
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            clkout_cnt          <= '0;
            clock_pin_out       <= 1'b0;
            clock_pin_oe_n_out  <= 1'b1;
            feedback_enable_out <= 1'b1;
        end else begin
            clkout_cnt <= clkout_cnt + 2'h1;
            clock_pin_out <= clkout_cnt[1];
            clock_pin_oe_n_out <= !(external_clock_mode_in
                                    && clock_out_enable_in);
            feedback_enable_out <= !external_clock_mode_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Secondary oscillator

    logic secondary_osc_req;
    assign secondary_osc_req = (|secondary_osc_enable_in)
        || (!sleep_in && cur_sel == SEL_SECONDARY_OSC)
        || (!sleep_in && osc_config_select_in == SEL_SECONDARY_OSC)
        || (!sleep_in && new_osc_select_in == SEL_SECONDARY_OSC);

    // Crystal or digital input mode
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            secondary_osc_run_out     <= 1'b0;
            crystal_driver_out        <= 1'b0;
            secondary_clock_input_out <= 1'b0;
            secondary_in_is_port_out  <= 1'b0;
        end else begin
            secondary_osc_run_out     <= secondary_osc_req;
            crystal_driver_out        <= secondary_osc_req && !digital_secondary_osc;
            secondary_clock_input_out <= digital_secondary_osc;
            secondary_in_is_port_out  <= digital_secondary_osc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fast RC oscillator and postscaler

    logic frc_used;
    assign frc_used = (cur_sel == SEL_FRC_DIV) || (cur_sel == SEL_FRC_DIV16)
                   || (cur_sel == SEL_FRC_PLL) || (cur_sel == SEL_FRC);

    // Enable, frequency and PLL compatibility
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fast_rc_run_out    <= 1'b1;
            fast_rc_khz_out    <= 16'(FRC_KHZ);
            fast_rc_pll_ok_out <= 1'b1;
        end else begin
            fast_rc_run_out <= !powerup_done_in || frc_used;
            fast_rc_khz_out <= (cur_sel == SEL_FRC_DIV)
                ? 16'(FRC_KHZ >> fast_rc_postscale_in)
                : 16'(FRC_KHZ);
            fast_rc_pll_ok_out <= (cur_sel != SEL_FRC_PLL)
                || (fast_rc_postscale_in <= 3'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            current_osc_select_out <= SEL_FRC;
            status_out             <= '0;
        end else begin
            current_osc_select_out <= cur_sel;
            status_out <= 8'(locked) << LOCK_BIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_lock_clear_off: assert property (
        !pll_src |=> !status_out[LOCK_BIT])
        else $error("lock set while off PLL");
    a_lock_timer: assert property (
        $rose(locked) |-> lock_cnt == 16'(LOCK_COUNT))
        else $error("lock set at wrong count");
    a_usb_clock: assert property (
        usb_enable_in && !usb_suspend_in
        |=> usb_clk_khz_out == 16'(USB_KHZ))
        else $error("usb clock missing");
    a_usb_off: assert property (
        !usb_enable_in |=> !usb_clk_enable_out)
        else $error("usb clock on while disabled");
    a_clkout_pin: assert property (
        !clock_out_enable_in |=> clock_pin_oe_n_out)
        else $error("clock pin driven while disabled");
    a_ext_feedback: assert property (
        external_clock_mode_in |=> !feedback_enable_out)
        else $error("feedback on in external mode");
    a_pll_keep: assert property (
        pll_keep_on_in |=> pll_run_out)
        else $error("pll stopped while kept on");
    a_secondary_osc_timer_run: assert property (
        |secondary_osc_enable_in |=> secondary_osc_run_out)
        else $error("secondary osc stopped");
    a_secondary_osc_digital: assert property (
        digital_secondary_osc |=> !crystal_driver_out)
        else $error("crystal driver on in digital mode");
    a_sys_divider: assert property (
        pll_src && cpu_clock_divider_in == 2'h3
        |=> sys_clk_khz_out == 16'(SYS_BASE_KHZ >> 3))
        else $error("divide-by-8 wrong");
    a_frc_reset_on: assert property (
        !powerup_done_in |=> fast_rc_run_out)
        else $error("fast rc off before power-up done");
    a_frc_postscale: assert property (
        cur_sel == SEL_FRC_DIV && fast_rc_postscale_in == 3'h7
        |=> fast_rc_khz_out == 16'(FRC_KHZ >> 7))
        else $error("postscaler wrong");
    a_frc_pll_ok: assert property (
        cur_sel == SEL_FRC_PLL && fast_rc_postscale_in > 3'h1
        |=> !fast_rc_pll_ok_out)
        else $error("postscale allowed with fast rc pll");
    a_prescale: assert property (
        pll_input_divider_in == 3'h7 |=> prescale_ratio_out == 4'hc)
        else $error("prescaler table wrong");

    c_lock_reached: cover property ($rose(locked));
    c_usb_on: cover property ($rose(usb_clk_enable_out));
    c_secondary_osc_digital: cover property (digital_secondary_osc);
    c_frc_divided: cover property (cur_sel == SEL_FRC_DIV);
    c_clock_out: cover property (!clock_pin_oe_n_out);

endmodule // usb_pll_clock_tree

`default_nettype wire

// ### testbench/ext_clock_source.sv
/*
 * Far-side model: external clock driver at one of the eight primary rates
 * that suit USB, plus its free-running clock line.
 * Assumes the bench picks the rate index; index equals the divider code.
 */
`default_nettype none

module ext_clock_source (
    input  wire logic        clk_in,
    input  wire logic [2:0]  pick_in,
    output var  logic [15:0] primary_khz_out,
    output var  logic        ext_clk_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // Rates in kHz: 4, 8, 12, 16, 20, 24, 32, 48 MHz
    logic [15:0] rate [8] = '{16'h0fa0, 16'h1f40, 16'h2ee0, 16'h3e80,
                              16'h4e20, 16'h5dc0, 16'h7d00, 16'hbb80};

    // Only rates from the valid table are offered
    always_comb primary_khz_out = rate[pick_in];

    // CMOS driver runs free, never parks
    initial ext_clk_out = 1'b0;
    always @(posedge clk_in) ext_clk_out <= ~ext_clk_out;

endmodule // ext_clock_source

`default_nettype wire

// ### testbench/usb_pll_clock_tree_tb.sv
/*
 * Self-checking bench of the clock tree control block.
 * Assumes outputs settle one edge after inputs; inputs move on negedge.
 */
`default_nettype none

module usb_pll_clock_tree_tb import clock_tree_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LOCK_N = 4;
    logic        clk_in = 1'b0, rst_in = 1'b1, sw = 1'b0, ext_mode = 1'b0;
    logic        co_en = 1'b0, usb_en = 1'b0, usb_susp = 1'b0, slp = 1'b0;
    logic        keep = 1'b0, pwr_done = 1'b0, ext_clk;
    logic [2:0]  new_sel = 3'h0, in_div = 3'h0, tmr_en = 3'h0, ps = 3'h0;
    logic [2:0]  pick = 3'h0, cfg_sel = 3'h0, cur_sel;
    logic [1:0]  mult = 2'h0, cpu_div = 2'h0, secondary_osc_mode = 2'h0;
    logic [15:0] pri_khz, usb_khz, sys_khz, frc_khz;
    logic [7:0]  status;
    logic [3:0]  mult_r, pre_r;
    logic        pin, oe_n, fb, ref_ok, pll_run, usb_on, secondary_osc_run;
    logic        xtal_drv, sclk_in, secondary_in_pin_port, frc_run, frc_ok;
    int          n_mismatch = 0, checks = 0, cyc = 0, k, hi;
    int          pre_tab [8] = '{1, 2, 3, 4, 5, 6, 8, 12};
    int          mul_tab [3] = '{4, 6, 8};
    logic [31:0] rng = 32'hf9076967;

    ////////////////////////////////////////////////////////////////////////
    // Clock and far side
    always #12.5 clk_in = ~clk_in;

    ext_clock_source u_ext_clock_source (.clk_in(clk_in), .pick_in(pick),
        .primary_khz_out(pri_khz), .ext_clk_out(ext_clk));

    usb_pll_clock_tree #(.LOCK_COUNT(LOCK_N)) u_usb_pll_clock_tree (
        .clk_in(clk_in), .rst_in(rst_in), .osc_config_select_in(cfg_sel),
        .new_osc_select_in(new_sel), .switch_request_in(sw),
        .external_clock_mode_in(ext_mode), .clock_out_enable_in(co_en),
        .sys_clk_in(ext_clk), .mult_factor_in(mult),
        .pll_input_divider_in(in_div), .cpu_clock_divider_in(cpu_div),
        .primary_khz_in(pri_khz), .usb_enable_in(usb_en),
        .usb_suspend_in(usb_susp), .secondary_osc_enable_in(tmr_en),
        .secondary_osc_mode_in(secondary_osc_mode), .sleep_in(slp),
        .pll_keep_on_in(keep), .powerup_done_in(pwr_done),
        .fast_rc_postscale_in(ps), .current_osc_select_out(cur_sel),
        .status_out(status), .clock_pin_out(pin),
        .clock_pin_oe_n_out(oe_n), .feedback_enable_out(fb),
        .mult_ratio_out(mult_r), .prescale_ratio_out(pre_r),
        .ref_valid_out(ref_ok), .pll_run_out(pll_run),
        .usb_clk_enable_out(usb_on), .usb_clk_khz_out(usb_khz),
        .sys_clk_khz_out(sys_khz), .secondary_osc_run_out(secondary_osc_run),
        .crystal_driver_out(xtal_drv),
        .secondary_clock_input_out(sclk_in),
        .secondary_in_is_port_out(secondary_in_pin_port),
        .fast_rc_run_out(frc_run), .fast_rc_khz_out(frc_khz),
        .fast_rc_pll_ok_out(frc_ok));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // One-cycle switch pulse, then wait for the select to reach the output
    task automatic switch_to(input logic [2:0] s);
        new_sel = s;
        sw = 1'b1;
        step(1);
        sw = 1'b0;
        step(2);
    endtask

    task automatic give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        step(10);
        rst_in = 1'b0;
        step(2);
        chk_val(16'(cur_sel), 16'(SEL_FRC));
        chk_val(16'(status), 16'h0000);
        chk_bit(frc_run, 1'b1);
        chk_val(frc_khz, 16'(FRC_KHZ));
        chk_bit(fb, 1'b1);
        pwr_done = 1'b1;
        // Divider codes against partner rates
        for (int i = 0; i < 8; i++) begin
            pick = 3'(i);
            in_div = 3'(i);
            step(2);
            chk_val(16'(pre_r), 16'(pre_tab[i]));
            chk_bit(ref_ok, 1'b1);
        end
        pick = 3'h1;
        in_div = 3'h0;
        step(2);
        chk_bit(ref_ok, 1'b0);
        for (int i = 0; i < 3; i++) begin
            mult = 2'(i);
            step(2);
            chk_val(16'(mult_r), 16'(mul_tab[i]));
        end
        // PLL source, lock timer
        pick = 3'h3;
        in_div = 3'h3;
        switch_to(SEL_PRI_PLL);
        chk_val(16'(cur_sel), 16'(SEL_PRI_PLL));
        chk_bit(status[LOCK_BIT], 1'b0);
        for (k = 0; k < 12 && status[LOCK_BIT] !== 1'b1; k++) step(1);
        chk_bit(status[LOCK_BIT], 1'b1);
        chk_val(16'(k), 16'(LOCK_N - 1));
        usb_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            cpu_div = 2'(i);
            step(2);
            chk_val(sys_khz, 16'(SYS_BASE_KHZ >> i));
            chk_bit(usb_on, 1'b1);
            chk_val(usb_khz, 16'(USB_KHZ));
        end
        usb_susp = 1'b1;
        step(2);
        chk_bit(usb_on, 1'b0);
        usb_susp = 1'b0;
        usb_en = 1'b0;
        // Random divider with USB off, divide-by-8 allowed
        repeat (6) begin
            rng = next_rand(rng);
            cpu_div = rng[1:0];
            step(2);
            chk_val(sys_khz, 16'(SYS_BASE_KHZ >> rng[1:0]));
        end
        switch_to(SEL_FRC);
        chk_bit(status[LOCK_BIT], 1'b0);
        chk_val(sys_khz, 16'(FRC_KHZ));
        keep = 1'b1;
        step(2);
        chk_bit(pll_run, 1'b1);
        keep = 1'b0;
        step(2);
        chk_bit(pll_run, 1'b0);
        switch_to(SEL_PRI);
        chk_bit(frc_run, 1'b0);
        chk_bit(status[LOCK_BIT], 1'b0);
        switch_to(SEL_FRC_DIV16);
        chk_bit(frc_run, 1'b1);
        switch_to(SEL_LPRC);
        chk_bit(frc_run, 1'b0);
        // Fast RC through the PLL: only the two top steps fit
        switch_to(SEL_FRC_PLL);
        for (int i = 0; i < 8; i++) begin
            ps = 3'(i);
            step(2);
            chk_bit(frc_ok, i < 2);
        end
        // Postscaler steps
        switch_to(SEL_FRC_DIV);
        for (int i = 0; i < 8; i++) begin
            ps = 3'(i);
            step(2);
            chk_val(frc_khz, 16'(FRC_KHZ >> i));
            chk_bit(frc_ok, 1'b1);
            chk_bit(frc_run, 1'b1);
        end
        ps = 3'h0;
        // Secondary oscillator requests
        switch_to(SEL_FRC);
        chk_bit(secondary_osc_run, 1'b0);
        cfg_sel = SEL_SECONDARY_OSC;
        step(2);
        chk_bit(secondary_osc_run, 1'b1);
        cfg_sel = SEL_FRC;
        new_sel = SEL_SECONDARY_OSC;
        step(2);
        chk_bit(secondary_osc_run, 1'b1);
        slp = 1'b1;
        for (int i = 0; i < 3; i++) begin
            tmr_en = 3'h1 << i;
            step(2);
            chk_bit(secondary_osc_run, 1'b1);
        end
        tmr_en = 3'h0;
        slp = 1'b0;
        switch_to(SEL_SECONDARY_OSC);
        chk_bit(secondary_osc_run, 1'b1);
        chk_bit(xtal_drv, 1'b1);
        slp = 1'b1;
        step(2);
        chk_bit(secondary_osc_run, 1'b0);
        slp = 1'b0;
        secondary_osc_mode = SECONDARY_OSC_MODE_DIGITAL;
        step(2);
        chk_bit(xtal_drv, 1'b0);
        chk_bit(sclk_in, 1'b1);
        chk_bit(secondary_in_pin_port, 1'b1);
        switch_to(SEL_FRC);
        chk_val(16'(cur_sel), 16'(SEL_SECONDARY_OSC));
        secondary_osc_mode = 2'h0;
        // External clock mode pin use
        ext_mode = 1'b1;
        co_en = 1'b1;
        step(2);
        chk_bit(oe_n, 1'b0);
        chk_bit(fb, 1'b0);
        hi = 0;
        repeat (8) begin
            k = int'(pin);
            step(1);
            hi += (int'(pin) != k);
        end
        chk_val(16'(hi), 16'h0004);
        co_en = 1'b0;
        step(2);
        chk_bit(oe_n, 1'b1);
        give_verdict();
    end

endmodule // usb_pll_clock_tree_tb

`default_nettype wire
